// file: hdl/btg_billing_tone.sv
// billing tone generator: registers, cadence, ticks and DAC output
`timescale 1ns/1ns
`default_nettype none
module btg_billing_tone #(
   parameter int SAMPLE_CYCLES = btg_pkg::SAMPLE_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // direct register access
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // DAC stream
   output logic [15:0] dac_sample,
   output logic dac_valid,
   // interrupt
   output logic int_n
);
   // ****************************************************************
   // sample and frame ticks
   // ****************************************************************
   logic [15:0] div_cnt;
   logic [2:0] sub_cnt;
   logic sample_tick;
   logic frame_tick;

   assign sample_tick = (div_cnt == 16'(SAMPLE_CYCLES - 1));
   assign frame_tick = sample_tick &&
      (sub_cnt == 3'(btg_pkg::SAMPLES_PER_FRAME - 1));

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 16'h0000;
      end else if (sample_tick) begin
         div_cnt <= 16'h0000;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // eight sinusoid samples make one cadence frame
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sub_cnt <= 3'h0;
      end else if (sample_tick) begin
         sub_cnt <= sub_cnt + 3'h1;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [15:0] ramp_rate;
   logic [15:0] amp_coeff;
   logic [15:0] freq_coeff;
   logic [15:0] ind_data;
   logic [15:0] active_time;
   logic [15:0] inactive_time;
   logic osc_en;
   logic act_en;
   logic inact_en;
   logic [1:0] int_enable;
   logic [1:0] int_status;
   logic ind_wr;
   logic ind_rd;

   assign ind_wr = reg_wr && (reg_addr == btg_pkg::ADDR_IND_WRITE);
   assign ind_rd = reg_wr && (reg_addr == btg_pkg::ADDR_IND_READ);

   // indirect space only through the data and address registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ramp_rate <= btg_pkg::REG16_RESET;
         amp_coeff <= btg_pkg::REG16_RESET;
         freq_coeff <= btg_pkg::REG16_RESET;
      end else if (ind_wr) begin
         case (reg_wdata)
            btg_pkg::IND_RAMP_RATE: ramp_rate <= ind_data;
            btg_pkg::IND_AMPLITUDE: amp_coeff <= ind_data;
            btg_pkg::IND_FREQUENCY: freq_coeff <= ind_data;
            default: ;
         endcase
      end
   end

   // data pair is written by software or filled by an indirect read
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ind_data <= btg_pkg::REG16_RESET;
      end else if (ind_rd) begin
         case (reg_wdata)
            btg_pkg::IND_RAMP_RATE: ind_data <= ramp_rate;
            btg_pkg::IND_AMPLITUDE: ind_data <= amp_coeff;
            btg_pkg::IND_FREQUENCY: ind_data <= freq_coeff;
            default: ind_data <= btg_pkg::REG16_RESET;
         endcase
      end else if (reg_wr && reg_addr == btg_pkg::ADDR_IND_DATA_LO) begin
         ind_data[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == btg_pkg::ADDR_IND_DATA_HI) begin
         ind_data[15:8] <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         active_time <= btg_pkg::REG16_RESET;
         inactive_time <= btg_pkg::REG16_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            btg_pkg::ADDR_ACTIVE_LO: active_time[7:0] <= reg_wdata;
            btg_pkg::ADDR_ACTIVE_HI: active_time[15:8] <= reg_wdata;
            btg_pkg::ADDR_INACTIVE_LO: inactive_time[7:0] <= reg_wdata;
            btg_pkg::ADDR_INACTIVE_HI: inactive_time[15:8] <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_en <= 1'b0;
         act_en <= 1'b0;
         inact_en <= 1'b0;
      end else if (reg_wr && reg_addr == btg_pkg::ADDR_CONTROL) begin
         osc_en <= reg_wdata[btg_pkg::CTL_OSC_EN_BIT];
         act_en <= reg_wdata[btg_pkg::CTL_ACT_EN_BIT];
         inact_en <= reg_wdata[btg_pkg::CTL_INACT_EN_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_enable <= 2'h0;
      end else if (reg_wr && reg_addr == btg_pkg::ADDR_INT_ENABLE) begin
         int_enable <= reg_wdata[1:0];
      end
   end

   // ****************************************************************
   // cadence
   // ****************************************************************
   btg_pkg::btg_cadence_e cadence;
   btg_pkg::btg_cadence_e next_cadence;
   logic [15:0] timer;
   logic timer_done;
   logic act_expire;
   logic inact_expire;
   logic tone_on;
   logic start;

   assign timer_done = frame_tick && (timer == 16'h0000);
   assign act_expire = (cadence == btg_pkg::BTG_ACTIVE) && act_en &&
      timer_done;
   assign inact_expire = (cadence == btg_pkg::BTG_INACTIVE) && inact_en &&
      timer_done;
   assign tone_on = osc_en && (cadence == btg_pkg::BTG_ACTIVE);

   always_comb begin
      next_cadence = cadence;
      case (cadence)
         btg_pkg::BTG_IDLE: begin
            if (osc_en) begin
               next_cadence = btg_pkg::BTG_ACTIVE;
            end
         end
         btg_pkg::BTG_ACTIVE: begin
            if (!osc_en) begin
               next_cadence = btg_pkg::BTG_IDLE;
            end else if (act_expire) begin
               next_cadence = btg_pkg::BTG_INACTIVE;
            end
         end
         btg_pkg::BTG_INACTIVE: begin
            if (!osc_en) begin
               next_cadence = btg_pkg::BTG_IDLE;
            end else if (inact_expire) begin
               next_cadence = btg_pkg::BTG_ACTIVE;
            end
         end
         default: next_cadence = btg_pkg::BTG_IDLE;
      endcase
   end

   // oscillator restarts at each new on interval
   assign start = (next_cadence == btg_pkg::BTG_ACTIVE) &&
      (cadence != btg_pkg::BTG_ACTIVE);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cadence <= btg_pkg::BTG_IDLE;
      end else begin
         cadence <= next_cadence;
      end
   end

   // each interval reloads its own duration and counts 8 kHz frames
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         timer <= 16'h0000;
      end else if (start) begin
         timer <= active_time;
      end else if (act_expire && osc_en) begin
         timer <= inactive_time;
      end else if (frame_tick && timer != 16'h0000) begin
         timer <= timer - 16'h0001;
      end
   end

   // ****************************************************************
   // interrupt status
   // ****************************************************************
   logic [1:0] int_set;
   logic [1:0] int_clr;

   assign int_set = {inact_expire, act_expire} & int_enable;
   assign int_clr = (reg_wr && reg_addr == btg_pkg::ADDR_INT_STATUS) ?
      reg_wdata[1:0] : 2'h0;

   // a new event wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_status <= 2'h0;
      end else begin
         int_status <= (int_status & ~int_clr) | int_set;
      end
   end

   assign int_n = ~|int_status;

   // ****************************************************************
   // tone path
   // ****************************************************************
   logic [15:0] osc_sample;
   logic [15:0] volume;
   logic signed [32:0] scaled;

   btg_oscillator u_osc (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .restart(start),
      .sample_tick(sample_tick),
      .freq_coeff(freq_coeff),
      .amp_coeff(amp_coeff),
      .sample(osc_sample)
   );

   btg_envelope u_env (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .frame_tick(frame_tick),
      .tone_on(tone_on),
      .ramp_rate(ramp_rate),
      .volume(volume)
   );

   assign scaled = $signed(osc_sample) * $signed({1'b0, volume});

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dac_sample <= 16'h0000;
         dac_valid <= 1'b0;
      end else begin
         dac_valid <= sample_tick;
         if (sample_tick) begin
            dac_sample <= scaled[30:15];
         end
      end
   end

   // ****************************************************************
   // read back
   // ****************************************************************
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         btg_pkg::ADDR_CONTROL: begin
            next_rdata[btg_pkg::CTL_OSC_EN_BIT] = osc_en;
            next_rdata[btg_pkg::CTL_INACT_EN_BIT] = inact_en;
            next_rdata[btg_pkg::CTL_ACT_EN_BIT] = act_en;
            next_rdata[btg_pkg::CTL_STATE_BIT] = tone_on;
         end
         btg_pkg::ADDR_INT_STATUS: next_rdata = {6'h00, int_status};
         btg_pkg::ADDR_INT_ENABLE: next_rdata = {6'h00, int_enable};
         btg_pkg::ADDR_IND_DATA_LO: next_rdata = ind_data[7:0];
         btg_pkg::ADDR_IND_DATA_HI: next_rdata = ind_data[15:8];
         btg_pkg::ADDR_ACTIVE_LO: next_rdata = active_time[7:0];
         btg_pkg::ADDR_ACTIVE_HI: next_rdata = active_time[15:8];
         btg_pkg::ADDR_INACTIVE_LO: next_rdata = inactive_time[7:0];
         btg_pkg::ADDR_INACTIVE_HI: next_rdata = inactive_time[15:8];
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end
endmodule : btg_billing_tone
`default_nettype wire

// file: hdl/btg_envelope.sv
// linear volume envelope for the billing tone
`timescale 1ns/1ns
`default_nettype none
module btg_envelope (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // control
   input wire logic frame_tick,
   input wire logic tone_on,
   input wire logic [15:0] ramp_rate,
   // output
   output logic [15:0] volume
);
   logic [16:0] sum;
   logic [15:0] next_volume;

   always_comb begin
      sum = {1'b0, volume} + {1'b0, ramp_rate};
      if (tone_on) begin
         if (sum >= {1'b0, btg_pkg::VOLUME_FULL}) begin
            next_volume = btg_pkg::VOLUME_FULL;
         end else begin
            next_volume = sum[15:0];
         end
      end else if (volume <= ramp_rate) begin
         next_volume = 16'h0000;
      end else begin
         next_volume = volume - ramp_rate;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         volume <= 16'h0000;
      end else if (frame_tick) begin
         volume <= next_volume;
      end
   end
endmodule : btg_envelope
`default_nettype wire

// file: hdl/btg_oscillator.sv
// recursive sinusoid oscillator for the billing tone
`timescale 1ns/1ns
`default_nettype none
module btg_oscillator (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // control
   input wire logic restart,
   input wire logic sample_tick,
   input wire logic [15:0] freq_coeff,
   input wire logic [15:0] amp_coeff,
   // output
   output logic [15:0] sample
);
   logic signed [15:0] y_cur;
   logic signed [15:0] y_prev;
   logic signed [31:0] product;
   logic signed [32:0] next_wide;
   logic signed [15:0] next_y;

   // y[n] = 2*c*y[n-1] - y[n-2], with c scaled by 2^15
   always_comb begin
      product = $signed(freq_coeff) * y_cur;
      next_wide = 33'(product >>> 14) - 33'(y_prev);
      if (next_wide > 33'sh0_0000_7FFF) begin
         next_y = 16'sh7FFF;
      end else if (next_wide < -33'sh0_0000_8000) begin
         next_y = -16'sh8000;
      end else begin
         next_y = next_wide[15:0];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         y_cur <= 16'sh0000;
         y_prev <= 16'sh0000;
      end else if (restart) begin
         // fixed starting phase: first output is zero
         y_cur <= $signed(amp_coeff);
         y_prev <= 16'sh0000;
      end else if (sample_tick) begin
         y_prev <= y_cur;
         y_cur <= next_y;
      end
   end

   assign sample = y_prev;
endmodule : btg_oscillator
`default_nettype wire

// file: hdl/btg_pkg.sv
// constants shared by the billing tone generator
//
// Summary of operation
// - sinusoid uses the recursive tone algorithm, updated at 64 kHz
// - oscillator always starts at phase zero; no phase register exists
// - cadence timers advance once per 8 kHz frame period
// - active and inactive durations are 16 bits over two byte registers each
// - while turning on, ramp rate is added to volume every 8 kHz tick
// - every oscillator sample is multiplied by volume before the DAC
// - when switched off, volume falls by ramp rate each tick to zero
// - one control register holds state bit and three enable bits
// - active and inactive timer expiry raise separate interrupt events
// - pending bit sets only if enabled; write one clears, zero keeps
// - active-low interrupt asserted while any status bit is set
package btg_pkg;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int SAMPLE_HZ = 64_000;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam int SAMPLES_PER_FRAME = 8;
   // ****************************************************************
   // direct register offsets
   // ****************************************************************
   localparam logic [6:0] ADDR_INT_STATUS = 7'h13;
   localparam logic [6:0] ADDR_INT_ENABLE = 7'h16;
   localparam logic [6:0] ADDR_IND_DATA_LO = 7'h1C;
   localparam logic [6:0] ADDR_IND_DATA_HI = 7'h1D;
   localparam logic [6:0] ADDR_IND_WRITE = 7'h1E;
   localparam logic [6:0] ADDR_IND_READ = 7'h1F;
   localparam logic [6:0] ADDR_CONTROL = 7'h23;
   localparam logic [6:0] ADDR_ACTIVE_LO = 7'h2C;
   localparam logic [6:0] ADDR_ACTIVE_HI = 7'h2D;
   localparam logic [6:0] ADDR_INACTIVE_LO = 7'h2E;
   localparam logic [6:0] ADDR_INACTIVE_HI = 7'h2F;
   // ****************************************************************
   // indirect register offsets
   // ****************************************************************
   localparam logic [7:0] IND_RAMP_RATE = 8'h17;
   localparam logic [7:0] IND_AMPLITUDE = 8'h18;
   localparam logic [7:0] IND_FREQUENCY = 8'h19;
   // ****************************************************************
   // field positions and values
   // ****************************************************************
   localparam int CTL_OSC_EN_BIT = 0;
   localparam int CTL_INACT_EN_BIT = 1;
   localparam int CTL_ACT_EN_BIT = 2;
   localparam int CTL_STATE_BIT = 3;
   localparam int INT_ACTIVE_BIT = 0;
   localparam int INT_INACTIVE_BIT = 1;
   localparam logic [15:0] VOLUME_FULL = 16'h7FFF;
   localparam logic [15:0] REG16_RESET = 16'h0000;
   localparam logic [7:0] REG8_RESET = 8'h00;
   typedef enum logic [1:0] {
      BTG_IDLE = 2'b00,
      BTG_ACTIVE = 2'b01,
      BTG_INACTIVE = 2'b10
   } btg_cadence_e;
endpackage : btg_pkg

// file: sim/btg_billing_tone_checker.sv
// port assertions for the billing tone generator
`timescale 1ns/1ns
`default_nettype none
module btg_billing_tone_checker #(
   parameter int SAMPLE_CYCLES = 4
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // register bus
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // stream and interrupt
   input wire logic [15:0] dac_sample,
   input wire logic dac_valid,
   input wire logic int_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic [2:0] ctl_seen;
   logic [15:0] gap;
   logic gap_ok;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) ctl_seen <= 3'h0;
      else if (reg_wr && reg_addr == btg_pkg::ADDR_CONTROL)
         ctl_seen <= reg_wdata[2:0];
   end
   // the first pulse after reset has no reference, so spacing starts later
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         gap <= 16'h0000;
         gap_ok <= 1'b0;
      end else if (dac_valid) begin
         gap <= 16'h0001;
         gap_ok <= 1'b1;
      end else gap <= gap + 16'h0001;
   end
   sequence s_ctl_read;
      reg_rd && !reg_wr && reg_addr == btg_pkg::ADDR_CONTROL;
   endsequence
   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read without valid answer");
   a_valid_cause: assert property (!reg_rd |=> !reg_rvalid)
      else $error("read valid without read");
   a_rdata_hold: assert property ($changed(reg_rdata) |-> reg_rvalid)
      else $error("read data changed outside answer");
   a_ctl_readback: assert property (s_ctl_read |=> reg_rvalid &&
      reg_rdata[2:0] == ctl_seen && (!reg_rdata[3] || ctl_seen[0]))
      else $error("control readback wrong");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 7'h7F
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_dac_spacing: assert property (dac_valid && gap_ok
      |-> gap == 16'(SAMPLE_CYCLES)) else $error("sample spacing wrong");
   a_dac_stable: assert property ($changed(dac_sample) |-> dac_valid)
      else $error("dac sample changed without valid");
   a_int_clear: assert property ($rose(int_n) |-> $past(reg_wr) &&
      $past(reg_addr) == btg_pkg::ADDR_INT_STATUS)
      else $error("interrupt released without status write");
   a_zero_keeps: assert property (reg_wr && !int_n && reg_wdata == 8'h00
      && reg_addr == btg_pkg::ADDR_INT_STATUS |=> !int_n)
      else $error("writing zero cleared a pending bit");
endmodule : btg_billing_tone_checker
bind btg_billing_tone btg_billing_tone_checker #(
   .SAMPLE_CYCLES(SAMPLE_CYCLES)
) i_chk (
   .core_clk(core_clk),
   .reset_n(reset_n),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid),
   .dac_sample(dac_sample),
   .dac_valid(dac_valid),
   .int_n(int_n)
);
`default_nettype wire

// file: sim/btg_host_model.sv
// host processor model on the register bus
`timescale 1ns/1ns
`default_nettype none
module btg_host_model (
   // clock
   input wire logic core_clk,
   // register bus
   output logic [6:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   logic ack_miss = 1'b0;
   initial begin
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr
   // answer comes one cycle after the strobe, taken before moving on
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      if (reg_rvalid !== 1'b1) ack_miss = 1'b1;
      d = reg_rdata;
   endtask : rd
   task automatic ind_wr(input logic [7:0] ia, input logic [15:0] v);
      wr(btg_pkg::ADDR_IND_DATA_LO, v[7:0]);
      wr(btg_pkg::ADDR_IND_DATA_HI, v[15:8]);
      wr(btg_pkg::ADDR_IND_WRITE, ia);
   endtask : ind_wr
   task automatic ind_rd(input logic [7:0] ia, output logic [15:0] v);
      wr(btg_pkg::ADDR_IND_READ, ia);
      rd(btg_pkg::ADDR_IND_DATA_LO, v[7:0]);
      rd(btg_pkg::ADDR_IND_DATA_HI, v[15:8]);
   endtask : ind_rd
endmodule : btg_host_model
`default_nettype wire

// file: sim/test_billing_tone_generator.sv
// self-checking testbench for the billing tone generator
`timescale 1ns/1ns
`default_nettype none
module test_billing_tone_generator;
   localparam int SC = 4;
   // 16 kHz tone: cosine term zero, amplitude at a quarter of full scale
   localparam logic [15:0] FREQ_16K = 16'h0000;
   localparam logic [15:0] AMP_FULL = 16'h1FFF;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [15:0] dac_sample;
   logic dac_valid;
   logic int_n;
   int mismatches = 0;
   int n_tests = 0;
   logic [15:0] seen_q[$];
   logic [15:0] last_s;
   int cyc = 0;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   btg_host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   btg_billing_tone #(.SAMPLE_CYCLES(SC)) i_dut (.core_clk(core_clk),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .dac_sample(dac_sample),
      .dac_valid(dac_valid), .int_n(int_n));
   task automatic chk(input string what, input logic [15:0] e,
      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   // keeps each new positive sample level, so the envelope steps show
   task automatic collect(input int n);
      int w;
      seen_q.delete();
      repeat (n) begin
         w = 0;
         @(negedge core_clk);
         while (dac_valid !== 1'b1 && w < 4 * SC) begin
            @(negedge core_clk);
            w++;
         end
         chk("sample wait", 16'h0000, 16'(w >= 4 * SC));
         last_s = dac_sample;
         if (last_s[15] === 1'b0 && last_s !== 16'h0000 &&
            (seen_q.size() == 0 || seen_q[$] !== last_s))
            seen_q.push_back(last_s);
      end
   endtask : collect
   task automatic chk_q(input logic [15:0] e[$]);
      chk("step count", 16'(e.size()), 16'(seen_q.size()));
      foreach (e[i]) chk("envelope step", e[i], seen_q[i]);
   endtask : chk_q
   task automatic t_regs;
      logic [7:0] d;
      logic [15:0] v;
      i_host.rd(btg_pkg::ADDR_CONTROL, d);
      chk("control reset", 16'h0000, {8'h00, d});
      chk("int_n idle", 16'h0001, {15'h0000, int_n});
      for (int i = 0; i < 4; i++) begin
         i_host.wr(7'(btg_pkg::ADDR_ACTIVE_LO + i), 8'(8'hA5 ^ i));
         i_host.ind_wr(8'(8'h17 + i % 3), 16'hC35A ^ 16'(i));
      end
      for (int i = 0; i < 4; i++) begin
         i_host.rd(7'(btg_pkg::ADDR_ACTIVE_LO + i), d);
         chk("timer byte", 16'(8'hA5 ^ i), {8'h00, d});
      end
      for (int i = 1; i < 4; i++) begin
         i_host.ind_rd(8'(8'h17 + i % 3), v);
         chk("indirect", 16'hC35A ^ 16'(i), v);
      end
      i_host.ind_rd(8'h00, v);
      chk("unknown indirect", 16'h0000, v);
      i_host.rd(7'h7F, d);
      chk("unmapped", 16'h0000, {8'h00, d});
   endtask : t_regs
   task automatic t_ramp;
      i_host.ind_wr(btg_pkg::IND_FREQUENCY, FREQ_16K);
      i_host.ind_wr(btg_pkg::IND_AMPLITUDE, AMP_FULL);
      i_host.ind_wr(btg_pkg::IND_RAMP_RATE, 16'h2000);
      i_host.wr(btg_pkg::ADDR_CONTROL, 8'h01);
      collect(64);
      chk_q({16'h07FF, 16'h0FFF, 16'h17FF, 16'h1FFE});
      i_host.wr(btg_pkg::ADDR_CONTROL, 8'h00);
      collect(64);
      if (seen_q.size() > 0 && seen_q[0] === 16'h1FFE)
         void'(seen_q.pop_front());
      chk_q({16'h17FF, 16'h0FFF, 16'h07FF});
      chk("faded sample", 16'h0000, last_s);
   endtask : t_ramp
   task automatic t_cadence;
      logic [7:0] d;
      logic [7:0] c;
      logic [7:0] first;
      int w;
      int t0;
      int t1;
      int exp_len;
      i_host.wr(btg_pkg::ADDR_ACTIVE_LO, 8'h02);
      i_host.wr(btg_pkg::ADDR_ACTIVE_HI, 8'h00);
      i_host.wr(btg_pkg::ADDR_INACTIVE_LO, 8'h03);
      i_host.wr(btg_pkg::ADDR_INACTIVE_HI, 8'h00);
      i_host.wr(btg_pkg::ADDR_CONTROL, 8'h07);
      i_host.rd(btg_pkg::ADDR_CONTROL, d);
      chk("on state", 16'h000F, {8'h00, d});
      repeat (64 * SC) @(negedge core_clk);
      i_host.rd(btg_pkg::ADDR_INT_STATUS, d);
      chk("masked status", 16'h0000, {8'h00, d});
      i_host.wr(btg_pkg::ADDR_INT_ENABLE, 8'h03);
      for (int k = 0; k < 2; k++) begin
         w = 0;
         while (int_n !== 1'b0 && w < 128 * SC) begin
            @(negedge core_clk);
            w++;
         end
         chk("event wait", 16'h0000, 16'(w >= 128 * SC));
         if (k == 0) t0 = cyc;
         else t1 = cyc;
         i_host.rd(btg_pkg::ADDR_INT_STATUS, d);
         i_host.rd(btg_pkg::ADDR_CONTROL, c);
         chk("one event", 16'h0001, 16'(d === 8'h01 || d === 8'h02));
         chk("interval", (d === 8'h01) ? 16'h0007 : 16'h000F, 16'(c));
         if (k == 0) first = d;
         else begin
            chk("other event", 16'(~first & 8'h03), 16'(d));
            // a timer loaded with N ends on its (N+1)th frame tick
            exp_len = (first === 8'h01) ? 32'h4 : 32'h3;
            exp_len = exp_len * btg_pkg::SAMPLES_PER_FRAME * SC;
            chk("interval cycles", 16'(exp_len), 16'(t1 - t0));
         end
         i_host.wr(btg_pkg::ADDR_INT_STATUS, 8'h00);
         chk("zero write", 16'h0000, {15'h0000, int_n});
         i_host.wr(btg_pkg::ADDR_INT_STATUS, d);
         chk("cleared", 16'h0001, {15'h0000, int_n});
      end
      i_host.wr(btg_pkg::ADDR_INT_ENABLE, 8'h00);
      i_host.wr(btg_pkg::ADDR_CONTROL, 8'h00);
   endtask : t_cadence
   initial begin
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      reset_n = 1'b1;
      t_regs();
      t_ramp();
      t_cadence();
      chk("read answers", 16'h0000, {15'h0000, i_host.ack_miss});
      summarize();
   end
   initial begin
      #3_000_000;
      mismatches++;
      summarize();
   end
endmodule : test_billing_tone_generator
`default_nettype wire
